/* bench/nbfr_asserts.sv */
`timescale 1ns/1ps
module nbfr_asserts
   import nbfr_pkg::*;
(
   input wire logic clock_i, // core clock
   input wire logic rst_i, // reset
   input wire logic buf_mode_i, // mode bit
   input wire logic wp_en_i, // protect bit
   input wire logic next_page_o, // page event
   input wire logic read_active_o, // active
   input wire logic spi_clk_i, // serial clock
   input wire logic cs_n_i, // select
   input wire logic [3:0] io_oe_o // enables
);
   logic [7:0] rise_cnt_reg = 8'h00; // rises since select, known before the first frame
   always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         rise_cnt_reg <= 8'h00;
      end else if (rise_cnt_reg != 8'hff) begin
         rise_cnt_reg <= rise_cnt_reg + 8'h01;
      end
   end
   hiz_idle_a: assert property (@(posedge clock_i) disable iff (rst_i)
      cs_n_i |-> io_oe_o == 4'h0) else $error("lanes driven while unselected");
   lane_set_a: assert property (@(negedge spi_clk_i) disable iff (rst_i)
      io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("bad lane enables");
   first_beat_a: assert property (@(negedge spi_clk_i) disable iff (rst_i || cs_n_i)
      $rose(io_oe_o != 4'h0) |-> (buf_mode_i ? rise_cnt_reg inside {8'h15, 8'h21, 8'h31}
      : rise_cnt_reg inside {8'h21, 8'h39, 8'h41})) else $error("data starts after wrong dummy count");
   quad_block_a: assert property (@(negedge spi_clk_i) disable iff (rst_i)
      wp_en_i |-> io_oe_o != 4'hf) else $error("quad output while protected");
   page_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
      next_page_o |=> !next_page_o) else $error("page event longer than one cycle");
   page_mode_a: assert property (@(posedge clock_i) disable iff (rst_i)
      next_page_o |-> !buf_mode_i) else $error("page event in buffer mode");
   active_on_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $fell(cs_n_i) |-> ##[1:3] read_active_o) else $error("active flag late");
   active_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(cs_n_i) |-> ##[1:3] !read_active_o) else $error("active flag stuck");
   cov_page: cover property (@(posedge clock_i) next_page_o);
   cov_quad: cover property (@(negedge spi_clk_i) io_oe_o == 4'hf);
   cov_dual: cover property (@(negedge spi_clk_i) io_oe_o == 4'h3);
endmodule : nbfr_asserts
bind nbfr_read_port nbfr_asserts i_chk (.*);

/* bench/nbfr_host.sv */
`timescale 1ns/1ps
module nbfr_host (
   output logic spi_clk_o, // serial clock
   output logic cs_n_o, // select
   output logic [3:0] drv_o, // host lanes
   input wire logic [3:0] io_w_i, // resolved lanes
   input wire logic [3:0] oe_i // device enables
);
   logic [7:0] got[$];
   logic [3:0] oe_seen;
   logic [3:0] smp;
   initial begin
      spi_clk_o = 1'b0;
      cs_n_o = 1'b1;
      drv_o = 4'h0;
   end
   // mode 0: change while low, sample on rise
   task automatic beat(input logic [3:0] v);
      drv_o = v;
      #3 spi_clk_o = 1'b1;
      smp = io_w_i;
      oe_seen = oe_seen | oe_i;
      #3 spi_clk_o = 1'b0;
   endtask : beat
   task automatic xfer(input logic [7:0] op, input logic [15:0] col, input int dum, input int w, input int nb);
      logic [7:0] b;
      cs_n_o = 1'b0;
      oe_seen = 4'h0;
      #5;
      for (int i = 7; i >= 0; i--) beat({3'h0, op[i]});
      if (op == 8'hbb) for (int i = 7; i >= 0; i--) beat({2'h0, col[2*i+1 -: 2]});
      else for (int i = 15; i >= 0; i--) beat({3'h0, col[i]});
      repeat (dum) beat(~drv_o);
      for (int n = 0; n < nb; n++) begin
         b = 8'h00;
         repeat (8 / w) begin
            beat(~drv_o);
            // four-state assembly; a lane the device leaves undriven reads back the host's own drive value
            if (w == 1) b = {b[6:0], smp[1]};
            else if (w == 2) b = {b[5:0], smp[1:0]};
            else b = {b[3:0], smp};
         end
         got.push_back(b);
      end
   endtask : xfer
   task automatic stop();
      #3 cs_n_o = 1'b1;
      #20;
   endtask : stop
endmodule : nbfr_host

/* bench/test_nand_buffer_fast_read_port.sv */
`timescale 1ns/1ps
module test_nand_buffer_fast_read_port;
   import nbfr_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   nbfr_load_type load_i = '0;
   logic buf_mode_i = 1'b1;
   logic wp_en_i = 1'b0;
   logic next_page_o, read_active_o, spi_clk_i, cs_n_i, page_seen = 1'b0;
   logic [3:0] io_o, io_oe_o, drv, io_w;
   int errors = 0, samples_checked = 0, cycles = 0;
   logic [7:0] mem[BUF_BYTES];
   logic [7:0] exp_q[$];
   logic [7:0] ops[7] = '{8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb};
   logic [15:0] seed = 16'h557c;
   always #12.5 clock_i = ~clock_i;
   assign io_w = (io_oe_o & io_o) | (~io_oe_o & drv);
   nbfr_read_port i_dut (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .load_i(load_i),
      .buf_mode_i(buf_mode_i),
      .wp_en_i(wp_en_i),
      .next_page_o(next_page_o),
      .read_active_o(read_active_o),
      .spi_clk_i(spi_clk_i),
      .cs_n_i(cs_n_i),
      .io_i(io_w),
      .io_o(io_o),
      .io_oe_o(io_oe_o)
   );
   nbfr_host i_host (.spi_clk_o(spi_clk_i), .cs_n_o(cs_n_i), .drv_o(drv), .io_w_i(io_w), .oe_i(io_oe_o));
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (next_page_o === 1'b1) page_seen <= 1'b1;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function int dum_of(input logic [7:0] op, input logic m);
      case (op)
         8'h0c, 8'h3c, 8'h6c: return m ? 24 : 40;
         8'hbb: return m ? 4 : 16;
         default: return m ? 8 : 32;
      endcase
   endfunction : dum_of
   function int lanes_of(input logic [7:0] op);
      case (op)
         8'h3b, 8'h3c, 8'hbb: return 2;
         8'h6b, 8'h6c: return 4;
         default: return 1;
      endcase
   endfunction : lanes_of
   task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk4
   task close_out();
      $display("checked %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   task run(input logic [7:0] op, input logic m, input logic [15:0] col, input int nb);
      exp_q = {};
      for (int n = 0; n < nb; n++) exp_q.push_back(m ? mem[col + n] : mem[n % BUF_BYTES]);
      @(posedge clock_i) buf_mode_i <= m;
      repeat (2) @(posedge clock_i);
      i_host.got = {};
      i_host.xfer(op, col, dum_of(op, m), lanes_of(op), nb);
      foreach (exp_q[k]) chk8("byte", exp_q[k], i_host.got[k]);
      #1;
      chk4("active flag", 4'h1, {3'h0, read_active_o});
      if (m && col + nb == BUF_BYTES) chk4("end enables", 4'h0, io_oe_o);
      i_host.stop();
      chk4("idle enables", 4'h0, io_oe_o);
      repeat (3) @(posedge clock_i);
      #1;
      chk4("idle active flag", 4'h0, {3'h0, read_active_o});
      $display("test op %h mode %0d done", op, m);
   endtask : run
   initial begin
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int a = 0; a < BUF_BYTES; a++) begin
         @(posedge clock_i);
         seed = lfsr(seed);
         load_i <= '{we: 1'b1, addr: a[11:0], data: seed[7:0]};
         mem[a] = seed[7:0];
      end
      @(posedge clock_i) load_i <= '0;
      foreach (ops[i]) for (int m = 0; m < 2; m++) begin
         seed = lfsr(seed);
         run(ops[i], m[0], seed % 16'h083c, 4);
      end
      run(8'h0c, 1'b1, 16'h083e, 2);
      chk4("page event", 4'h0, {3'h0, page_seen});
      run(8'h0b, 1'b0, 16'h0005, BUF_BYTES + 1);
      repeat (8) @(posedge clock_i);
      chk4("page event", 4'h1, {3'h0, page_seen});
      @(posedge clock_i);
      wp_en_i <= 1'b1;
      buf_mode_i <= 1'b1;
      // full dummy count, so an unrefused quad read would drive its lanes
      for (int i = 4; i < 6; i++) begin
         i_host.xfer(ops[i], 16'h0000, dum_of(ops[i], 1'b1), 4, 1);
         chk4("refused enables", 4'h0, i_host.oe_seen);
         i_host.stop();
      end
      i_host.xfer(8'h5a, 16'h0000, 8, 1, 1);
      chk4("unknown opcode enables", 4'h0, i_host.oe_seen);
      i_host.stop();
      i_host.xfer(8'h0b, BUF_END_COL, 8, 1, 1);
      chk4("past end enables", 4'h0, i_host.oe_seen);
      i_host.stop();
      $display("test protect done");
      run(8'h3b, 1'b1, 16'h0007, 2);
      close_out();
   end
endmodule : test_nand_buffer_fast_read_port

/* core/nbfr_pkg.sv */
package nbfr_pkg;
   // page buffer geometry
   localparam int BUF_BYTES = 2112;
   localparam int BUF_AW = 12;
   localparam logic [BUF_AW-1:0] BUF_LAST = 12'h83f;
   localparam logic [15:0] BUF_END_COL = 16'h0840;

   // instruction codes
   localparam logic [7:0] OPC_FAST = 8'h0b;
   localparam logic [7:0] OPC_FAST_4B = 8'h0c;
   localparam logic [7:0] OPC_DUAL = 8'h3b;
   localparam logic [7:0] OPC_DUAL_4B = 8'h3c;
   localparam logic [7:0] OPC_QUAD = 8'h6b;
   localparam logic [7:0] OPC_QUAD_4B = 8'h6c;
   localparam logic [7:0] OPC_DUAL_IO = 8'hbb;

   // phase lengths in serial clocks
   localparam logic [5:0] OPC_CLKS = 6'h08;
   localparam logic [5:0] COL_BITS = 6'h10;
   localparam logic [5:0] DUM_STD_BUF = 6'h08;
   localparam logic [5:0] DUM_STD_CONT = 6'h20;
   localparam logic [5:0] DUM_4B_BUF = 6'h18;
   localparam logic [5:0] DUM_4B_CONT = 6'h28;

   // lane count codes
   localparam logic [1:0] LANES_ONE = 2'h0;
   localparam logic [1:0] LANES_TWO = 2'h1;
   localparam logic [1:0] LANES_FOUR = 2'h2;

   typedef enum logic [2:0] {
      ST_OPC,
      ST_COL,
      ST_DUM,
      ST_DAT,
      ST_OFF
   } nbfr_state_type;

   typedef struct packed {
      logic [3:0] dat;
      logic [3:0] oe;
   } nbfr_pins_type;

   typedef struct packed {
      logic we;
      logic [BUF_AW-1:0] addr;
      logic [7:0] data;
   } nbfr_load_type;
endpackage : nbfr_pkg

/* core/nbfr_read_port.sv */
`timescale 1ns/1ps
module nbfr_read_port
   import nbfr_pkg::*;
(
   input wire logic clock_i,                      // core clock
   input wire logic rst_i,                        // async reset, high
   input wire nbfr_pkg::nbfr_load_type load_i,    // page buffer fill port
   input wire logic buf_mode_i,                   // status mode bit
   input wire logic wp_en_i,                      // write-protect-enable bit
   output logic next_page_o,                      // pulse: continuous read crossed a page
   output logic read_active_o,                    // chip select seen low
   input wire logic spi_clk_i,                    // serial clock from host
   input wire logic cs_n_i,                       // chip select, low active
   input wire logic [3:0] io_i,                   // lane inputs, lane zero is serial_data_input
   output logic [3:0] io_o,                       // lane outputs
   output logic [3:0] io_oe_o                     // lane output enables
);
   import nbfr_pkg::*;

   logic [7:0] buf_mem [0:BUF_BYTES-1];

   // buffer fill, core domain; host keeps it quiet while reading
   always_ff @(posedge clock_i) begin
      if (load_i.we) begin
         buf_mem[load_i.addr] <= load_i.data;
      end
   end

   // link side, apart from the page toggle, is held in reset whenever chip select is high
   logic link_rst;
   assign link_rst = rst_i | cs_n_i;

   logic bm_s1_reg;
   logic bm_s2_reg;
   logic wp_s1_reg;
   logic wp_s2_reg;
   always_ff @(posedge spi_clk_i or posedge link_rst) begin
      if (link_rst) begin
         bm_s1_reg <= 1'b0;
         bm_s2_reg <= 1'b0;
         wp_s1_reg <= 1'b0;
         wp_s2_reg <= 1'b0;
      end else begin
         bm_s1_reg <= buf_mode_i;
         bm_s2_reg <= bm_s1_reg;
         wp_s1_reg <= wp_en_i;
         wp_s2_reg <= wp_s1_reg;
      end
   end

   nbfr_state_type state_reg;
   nbfr_state_type state_next;
   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic [15:0] sh_reg;
   logic [15:0] sh_next;
   logic [1:0] lanes_reg;
   logic [1:0] lanes_next;
   logic dio_reg;
   logic dio_next;
   logic long_reg;
   logic long_next;
   logic bufm_reg;
   logic bufm_next;
   logic [BUF_AW-1:0] addr_reg;
   logic [BUF_AW-1:0] addr_next;
   logic [2:0] beat_reg;
   logic [2:0] beat_next;
   logic pg_tgl_reg;
   logic pg_tgl_next;

   logic [7:0] opc_w;
   logic [15:0] col_w;
   logic [5:0] col_clks;
   logic [5:0] dum_clks;
   logic [2:0] last_beat;

   always_comb begin
      opc_w = {sh_reg[6:0], io_i[0]};
      col_w = dio_reg ? {sh_reg[13:0], io_i[1:0]} : {sh_reg[14:0], io_i[0]};
      col_clks = dio_reg ? (COL_BITS >> 1) : COL_BITS;
      if (long_reg) begin
         dum_clks = bufm_reg ? DUM_4B_BUF : DUM_4B_CONT;
      end else begin
         dum_clks = bufm_reg ? DUM_STD_BUF : DUM_STD_CONT;
      end
      if (dio_reg) begin
         dum_clks = dum_clks >> 1;
      end
      unique case (lanes_reg)
         LANES_TWO: last_beat = 3'h3;
         LANES_FOUR: last_beat = 3'h1;
         default: last_beat = 3'h7;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 6'h01;
      sh_next = sh_reg;
      lanes_next = lanes_reg;
      dio_next = dio_reg;
      long_next = long_reg;
      bufm_next = bufm_reg;
      addr_next = addr_reg;
      beat_next = beat_reg;
      pg_tgl_next = pg_tgl_reg;
      unique case (state_reg)
         ST_OPC: begin
            sh_next = {sh_reg[14:0], io_i[0]};
            if (cnt_reg == OPC_CLKS - 6'h01) begin
               cnt_next = 6'h00;
               sh_next = 16'h0000;
               bufm_next = bm_s2_reg;
               state_next = ST_COL;
               dio_next = 1'b0;
               long_next = 1'b0;
               unique case (opc_w)
                  OPC_FAST: lanes_next = LANES_ONE;
                  OPC_FAST_4B: begin
                     lanes_next = LANES_ONE;
                     long_next = 1'b1;
                  end
                  OPC_DUAL: lanes_next = LANES_TWO;
                  OPC_DUAL_4B: begin
                     lanes_next = LANES_TWO;
                     long_next = 1'b1;
                  end
                  OPC_QUAD, OPC_QUAD_4B: begin
                     lanes_next = LANES_FOUR;
                     long_next = (opc_w == OPC_QUAD_4B);
                     if (wp_s2_reg) begin
                        state_next = ST_OFF;
                     end
                  end
                  OPC_DUAL_IO: begin
                     lanes_next = LANES_TWO;
                     dio_next = 1'b1;
                  end
                  default: state_next = ST_OFF;
               endcase
            end
         end
         ST_COL: begin
            sh_next = col_w;
            if (cnt_reg == col_clks - 6'h01) begin
               cnt_next = 6'h00;
               state_next = ST_DUM;
               if (bufm_reg) begin
                  addr_next = col_w[BUF_AW-1:0];
                  if (col_w >= BUF_END_COL) begin
                     state_next = ST_OFF;
                  end
               end else begin
                  addr_next = '0;
               end
            end
         end
         ST_DUM: begin
            if (cnt_reg == dum_clks - 6'h01) begin
               cnt_next = 6'h00;
               beat_next = 3'h0;
               state_next = ST_DAT;
            end
         end
         ST_DAT: begin
            cnt_next = 6'h00;
            beat_next = beat_reg + 3'h1;
            if (beat_reg == last_beat) begin
               beat_next = 3'h0;
               addr_next = addr_reg + 12'h001;
               if (addr_reg == BUF_LAST) begin
                  if (bufm_reg) begin
                     state_next = ST_OFF;
                  end else begin
                     addr_next = '0;
                     pg_tgl_next = ~pg_tgl_reg;
                  end
               end
            end
         end
         ST_OFF: begin
            cnt_next = 6'h00;
         end
      endcase
   end

   always_ff @(posedge spi_clk_i or posedge link_rst) begin
      if (link_rst) begin
         state_reg <= ST_OPC;
         cnt_reg <= 6'h00;
         sh_reg <= 16'h0000;
         lanes_reg <= LANES_ONE;
         dio_reg <= 1'b0;
         long_reg <= 1'b0;
         bufm_reg <= 1'b0;
         addr_reg <= '0;
         beat_reg <= 3'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         lanes_reg <= lanes_next;
         dio_reg <= dio_next;
         long_reg <= long_next;
         bufm_reg <= bufm_next;
         addr_reg <= addr_next;
         beat_reg <= beat_next;
      end
   end

   // page toggle survives chip select so no crossing is lost
   always_ff @(posedge spi_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pg_tgl_reg <= 1'b0;
      end else begin
         pg_tgl_reg <= pg_tgl_next;
      end
   end

   // pin drive, updated on falling serial clock
   nbfr_pins_type pins_reg;
   nbfr_pins_type pins_next;
   logic [7:0] cur_byte;
   logic [7:0] byte_sh;

   always_comb begin
      cur_byte = buf_mem[addr_reg];
      pins_next = '0;
      byte_sh = 8'h00;
      if (state_reg == ST_DAT) begin
         unique case (lanes_reg)
            LANES_TWO: begin
               byte_sh = cur_byte << {beat_reg[1:0], 1'b0};
               pins_next.dat = {2'b00, byte_sh[7:6]};
               pins_next.oe = 4'h3;
            end
            LANES_FOUR: begin
               byte_sh = cur_byte << {beat_reg[0], 2'b00};
               pins_next.dat = byte_sh[7:4];
               pins_next.oe = 4'hf;
            end
            default: begin
               byte_sh = cur_byte << beat_reg;
               pins_next.dat = {2'b00, byte_sh[7], 1'b0};
               pins_next.oe = 4'h2;
            end
         endcase
      end
   end

   always_ff @(negedge spi_clk_i or posedge link_rst) begin
      if (link_rst) begin
         pins_reg <= '0;
      end else begin
         pins_reg <= pins_next;
      end
   end

   assign io_o = pins_reg.dat;
   assign io_oe_o = pins_reg.oe;

   // core side status crossings
   logic act_s1_reg;
   logic act_s2_reg;
   logic pg_s1_reg;
   logic pg_s2_reg;
   logic pg_s3_reg;
   logic np_reg;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         act_s1_reg <= 1'b0;
         act_s2_reg <= 1'b0;
         pg_s1_reg <= 1'b0;
         pg_s2_reg <= 1'b0;
         pg_s3_reg <= 1'b0;
         np_reg <= 1'b0;
      end else begin
         act_s1_reg <= ~cs_n_i;
         act_s2_reg <= act_s1_reg;
         pg_s1_reg <= pg_tgl_reg;
         pg_s2_reg <= pg_s1_reg;
         pg_s3_reg <= pg_s2_reg;
         np_reg <= pg_s2_reg ^ pg_s3_reg;
      end
   end

   assign next_page_o = np_reg;
   assign read_active_o = act_s2_reg;
endmodule : nbfr_read_port
